//--- design/mahr_map.vh
`ifndef MAHR_MAP_VH
`define MAHR_MAP_VH
`define MAHR_OFS_ADDR_LOW    4'h3
`define MAHR_OFS_ADDR_HIGH   4'h2
`define MAHR_OFS_HASH_HIGH   4'h4
`define MAHR_OFS_HASH_LOW    4'h5
`define MAHR_OFS_CMD         4'h6
`define MAHR_OFS_DATA        4'h7
`define MAHR_OFS_FILT_CTRL   4'h9
`define MAHR_OFS_FILT_STAT   4'ha
`define MAHR_RST_ADDR_LOW    32'h0fff_ffff
`define MAHR_RST_ADDR_HIGH   16'hffff
`define MAHR_RST_ZERO        32'h0000_0000
`define MAHR_CMD_PHYAD_HI    15
`define MAHR_CMD_PHYAD_LO    11
`define MAHR_CMD_REG_HI      10
`define MAHR_CMD_REG_LO      6
`define MAHR_CMD_WRITE_BIT   1
`define MAHR_CMD_BUSY_BIT    0
`define MAHR_CTRL_PASS_BIT   0
`define MAHR_MDC_PERIOD_NS   400
`define MAHR_CLK_PERIOD_NS   8
`define MAHR_MDC_HALF_CYC    ((`MAHR_MDC_PERIOD_NS / `MAHR_CLK_PERIOD_NS) / 2)
`define MAHR_FRAME_BITS      64
`define MAHR_TA_BIT          46
`define MAHR_CRC_POLY        32'h04c1_1db7
`endif

//--- design/mahr_mdio.v
`timescale 1ns/1ps
`include "mahr_map.vh"
// clause-22 management frame engine: 32-bit preamble then st/op/phy/reg/ta/data
module mahr_mdio #(
    parameter HALF_CYC = `MAHR_MDC_HALF_CYC
) (
    input  wire        mclk,       // system clock
    input  wire        rstn,       // sync reset, active low
    input  wire        start,      // one-cycle start pulse
    input  wire        wr,         // 1 write frame, 0 read frame
    input  wire [4:0]  phy_addr,   // phy address field
    input  wire [4:0]  reg_idx,    // phy register index
    input  wire [15:0] wdata,      // write data
    input  wire        mdio_in,    // synchronised data from phy
    output reg         mdc,        // management clock
    output reg         mdio_o,     // data driven to phy
    output reg         mdio_oe_n,  // low while driving
    output reg         done,       // one-cycle completion pulse
    output reg  [15:0] rdata       // read result
);
    reg [7:0]  div_ff;
    reg [6:0]  bit_ff;
    reg [63:0] sh_ff;
    reg        act_ff;
    reg        wr_ff;
    wire       tick = (div_ff == HALF_CYC[7:0] - 8'h01);

    // mdc toggles each half period; data changes on falling, samples on rising
    always @(posedge mclk) begin
        if (!rstn) begin
            div_ff <= 8'h00; bit_ff <= 7'h00; sh_ff <= 64'h0000_0000_0000_0000;
            act_ff <= 1'b0; wr_ff <= 1'b0; mdc <= 1'b0; mdio_o <= 1'b1;
            mdio_oe_n <= 1'b1; done <= 1'b0; rdata <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (!act_ff) begin
                div_ff <= 8'h00;
                mdc <= 1'b0;
                if (start) begin
                    act_ff <= 1'b1; wr_ff <= wr; bit_ff <= 7'h00;
                    sh_ff <= {32'hffff_ffff, 2'b01, wr ? 2'b01 : 2'b10, phy_addr, reg_idx,
                              wr ? 2'b10 : 2'b11, wr ? wdata : 16'hffff};
                    mdio_oe_n <= 1'b0; mdio_o <= 1'b1;
                end
            end else if (tick) begin
                div_ff <= 8'h00;
                mdc <= ~mdc;
                if (mdc) begin
                    // falling edge: advance to the next bit
                    if (bit_ff == `MAHR_FRAME_BITS - 1) begin
                        act_ff <= 1'b0; mdio_oe_n <= 1'b1; mdio_o <= 1'b1;
                        done <= 1'b1;
                    end else begin
                        bit_ff <= bit_ff + 7'h01;
                        sh_ff <= {sh_ff[62:0], 1'b1};
                        mdio_o <= sh_ff[62];
                        // release the line for turnaround and data of a read
                        if (!wr_ff && bit_ff == `MAHR_TA_BIT - 1)
                            mdio_oe_n <= 1'b1;
                    end
                end else if (!wr_ff && bit_ff >= `MAHR_TA_BIT + 2) begin
                    rdata <= {rdata[14:0], mdio_in};
                end
            end else begin
                div_ff <= div_ff + 8'h01;
            end
        end
    end
endmodule

//--- design/mahr_regs.v
`timescale 1ns/1ps
`include "mahr_map.vh"
module mahr_regs #(
    parameter HALF_CYC = `MAHR_MDC_HALF_CYC
) (
    input  wire        mclk,          // 125 MHz system clock
    input  wire        rstn,          // sync reset, active low
    input  wire [3:0]  reg_addr,      // register index
    input  wire [31:0] reg_wdata,     // write data
    input  wire        reg_wr,        // write strobe
    input  wire        reg_rd,        // read strobe
    output reg  [31:0] reg_rdata,     // read data, cycle after strobe
    input  wire        ee_valid,      // eeprom byte valid strobe
    input  wire [2:0]  ee_index,      // eeprom byte address 1..6
    input  wire [7:0]  ee_byte,       // eeprom byte value
    input  wire        ee_done,       // eeprom load finished pulse
    input  wire        ee_programmed, // programmed eeprom detected
    input  wire        rx_byte_vld,   // destination address byte strobe
    input  wire [7:0]  rx_byte,       // destination address byte, wire order
    input  wire        rx_da_start,   // first byte of a new address
    output reg         mc_check,      // one-cycle: verdict valid
    output reg         mc_accept,     // multicast verdict
    output reg  [47:0] station_addr,  // assembled station address
    output reg         init_done,     // address load finished
    input  wire        mdio_pin,      // management data from pin
    output reg         mdc,           // management clock
    output reg         mdio_out,      // management data out
    output reg         mdio_oe_n      // low while driving mdio
);
    reg [31:0] addr_low_ff;
    reg [15:0] addr_high_ff;
    reg [31:0] hash_high_ff;
    reg [31:0] hash_low_ff;
    reg [4:0]  phy_ad_ff;
    reg [4:0]  phy_reg_index_ff;
    reg        phy_write_select_ff;
    reg        phy_access_busy_ff;
    reg [15:0] phy_data_ff;
    reg        pass_all_multicast_ff;
    reg [31:0] crc_ff;
    reg [2:0]  da_cnt_ff;
    reg [5:0]  last_idx_ff;
    reg        mdio_s1_ff;
    reg        mdio_s2_ff;
    reg        start_ff;
    wire       eng_mdc;
    wire       eng_mdio;
    wire       eng_oe_n;
    wire       eng_done;
    wire [15:0] eng_rdata;

    // crc of one byte, lsb first as bits leave the wire
    function [31:0] crc_byte;
        input [31:0] crc;
        input [7:0]  d;
        integer i;
        reg [31:0] c;
        begin
            c = crc;
            for (i = 0; i < 8; i = i + 1)
                c = (c[31] ^ d[i]) ? ({c[30:0], 1'b0} ^ `MAHR_CRC_POLY) : {c[30:0], 1'b0};
            crc_byte = c;
        end
    endfunction

    // hash bit lookup from a six-bit index
    function hash_bit;
        input [5:0]  idx;
        input [31:0] hi;
        input [31:0] lo;
        begin
            hash_bit = idx[5] ? hi[idx[4:0]] : lo[idx[4:0]];
        end
    endfunction

    // next crc with the current byte folded in; a call result cannot be sliced directly
    wire [31:0] crc_next = crc_byte(crc_ff, rx_byte);

    // two-stage synchroniser for the pin input
    always @(posedge mclk) begin
        if (!rstn) begin
            mdio_s1_ff <= 1'b1;
            mdio_s2_ff <= 1'b1;
        end else begin
            mdio_s1_ff <= mdio_pin;
            mdio_s2_ff <= mdio_s1_ff;
        end
    end

    mahr_mdio #(.HALF_CYC(HALF_CYC)) u_mahr_mdio (
        .mclk      (mclk),
        .rstn      (rstn),
        .start     (start_ff),
        .wr        (phy_write_select_ff),
        .phy_addr  (phy_ad_ff),
        .reg_idx   (phy_reg_index_ff),
        .wdata     (phy_data_ff),
        .mdio_in   (mdio_s2_ff),
        .mdc       (eng_mdc),
        .mdio_o    (eng_mdio),
        .mdio_oe_n (eng_oe_n),
        .done      (eng_done),
        .rdata     (eng_rdata)
    );

    // pins retimed so top outputs come straight from flops
    always @(posedge mclk) begin
        if (!rstn) begin
            mdc <= 1'b0;
            mdio_out <= 1'b1;
            mdio_oe_n <= 1'b1;
        end else begin
            mdc <= eng_mdc;
            mdio_out <= eng_mdio;
            mdio_oe_n <= eng_oe_n;
        end
    end

    // station address: eeprom load until init done, host writes afterwards
    always @(posedge mclk) begin
        if (!rstn) begin
            addr_low_ff <= `MAHR_RST_ADDR_LOW;
            addr_high_ff <= `MAHR_RST_ADDR_HIGH;
            init_done <= 1'b0;
        end else begin
            if (!init_done && ee_valid && ee_programmed) begin
                case (ee_index)
                    3'h1: addr_low_ff[7:0] <= ee_byte;
                    3'h2: addr_low_ff[15:8] <= ee_byte;
                    3'h3: addr_low_ff[23:16] <= ee_byte;
                    3'h4: addr_low_ff[31:24] <= ee_byte;
                    3'h5: addr_high_ff[7:0] <= ee_byte;
                    3'h6: addr_high_ff[15:8] <= ee_byte;
                    default: addr_low_ff <= addr_low_ff;
                endcase
            end
            if (ee_done)
                init_done <= 1'b1;
            // host writes accepted only after initialisation
            if (init_done && reg_wr && reg_addr == `MAHR_OFS_ADDR_LOW)
                addr_low_ff <= reg_wdata;
            if (init_done && reg_wr && reg_addr == `MAHR_OFS_ADDR_HIGH)
                addr_high_ff <= reg_wdata[15:0];
        end
    end

    // hash table and filter control registers
    always @(posedge mclk) begin
        if (!rstn) begin
            hash_high_ff <= `MAHR_RST_ZERO;
            hash_low_ff <= `MAHR_RST_ZERO;
            pass_all_multicast_ff <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `MAHR_OFS_HASH_HIGH)
                hash_high_ff <= reg_wdata;
            if (reg_addr == `MAHR_OFS_HASH_LOW)
                hash_low_ff <= reg_wdata;
            if (reg_addr == `MAHR_OFS_FILT_CTRL)
                pass_all_multicast_ff <= reg_wdata[`MAHR_CTRL_PASS_BIT];
        end
    end

    // management command and data; writes while busy are ignored
    always @(posedge mclk) begin
        if (!rstn) begin
            phy_ad_ff <= 5'h00;
            phy_reg_index_ff <= 5'h00;
            phy_write_select_ff <= 1'b0;
            phy_access_busy_ff <= 1'b0;
            phy_data_ff <= 16'h0000;
            start_ff <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            if (eng_done) begin
                if (!phy_write_select_ff)
                    phy_data_ff <= eng_rdata;
                phy_access_busy_ff <= 1'b0;
            end else if (!phy_access_busy_ff && reg_wr) begin
                if (reg_addr == `MAHR_OFS_CMD) begin
                    phy_ad_ff <= reg_wdata[`MAHR_CMD_PHYAD_HI:`MAHR_CMD_PHYAD_LO];
                    phy_reg_index_ff <= reg_wdata[`MAHR_CMD_REG_HI:`MAHR_CMD_REG_LO];
                    phy_write_select_ff <= reg_wdata[`MAHR_CMD_WRITE_BIT];
                    if (reg_wdata[`MAHR_CMD_BUSY_BIT]) begin
                        phy_access_busy_ff <= 1'b1;
                        start_ff <= 1'b1;
                    end
                end
                if (reg_addr == `MAHR_OFS_DATA)
                    phy_data_ff <= reg_wdata[15:0];
            end
        end
    end

    // destination address crc and multicast verdict after the sixth byte
    always @(posedge mclk) begin
        if (!rstn) begin
            crc_ff <= 32'hffff_ffff;
            da_cnt_ff <= 3'h0;
            last_idx_ff <= 6'h00;
            mc_check <= 1'b0;
            mc_accept <= 1'b0;
        end else begin
            mc_check <= 1'b0;
            if (rx_byte_vld) begin
                if (rx_da_start) begin
                    crc_ff <= crc_byte(32'hffff_ffff, rx_byte);
                    da_cnt_ff <= 3'h1;
                end else if (da_cnt_ff != 3'h0 && da_cnt_ff != 3'h6) begin
                    crc_ff <= crc_byte(crc_ff, rx_byte);
                    da_cnt_ff <= da_cnt_ff + 3'h1;
                    if (da_cnt_ff == 3'h5) begin
                        // index from the top six crc bits
                        last_idx_ff <= crc_next[31:26];
                        mc_check <= 1'b1;
                        mc_accept <= pass_all_multicast_ff |
                            hash_bit(crc_next[31:26],
                                     hash_high_ff, hash_low_ff);
                    end
                end
            end
        end
    end

    always @(posedge mclk) begin
        if (!rstn)
            station_addr <= {`MAHR_RST_ADDR_HIGH, `MAHR_RST_ADDR_LOW};
        else
            station_addr <= {addr_high_ff, addr_low_ff};
    end

    // read mux; unmapped indexes read zero
    always @(posedge mclk) begin
        if (!rstn)
            reg_rdata <= `MAHR_RST_ZERO;
        else if (reg_rd) begin
            case (reg_addr)
                `MAHR_OFS_ADDR_LOW:  reg_rdata <= addr_low_ff;
                `MAHR_OFS_ADDR_HIGH: reg_rdata <= {16'h0000, addr_high_ff};
                `MAHR_OFS_HASH_HIGH: reg_rdata <= hash_high_ff;
                `MAHR_OFS_HASH_LOW:  reg_rdata <= hash_low_ff;
                `MAHR_OFS_CMD:       reg_rdata <= {16'h0000, phy_ad_ff, phy_reg_index_ff,
                                                   4'h0, phy_write_select_ff,
                                                   phy_access_busy_ff};
                `MAHR_OFS_DATA:      reg_rdata <= {16'h0000, phy_data_ff};
                `MAHR_OFS_FILT_CTRL: reg_rdata <= {31'h0000_0000, pass_all_multicast_ff};
                `MAHR_OFS_FILT_STAT: reg_rdata <= {24'h00_0000, init_done, 1'b0, last_idx_ff};
                default:             reg_rdata <= `MAHR_RST_ZERO;
            endcase
        end else
            reg_rdata <= `MAHR_RST_ZERO;
    end
endmodule

//--- test/mahr_phy_model.sv
`timescale 1ns/1ps
// phy management slave: 32 registers behind a clause-22 frame decoder
module mahr_phy_model (
    input  wire mclk,      // clock
    input  wire mdc,       // mgmt clock
    input  wire mdio_out,  // block data
    input  wire mdio_oe_n, // block drives low
    output reg  phy_o,     // phy data
    output reg  phy_oe     // phy drives high
);
    reg [15:0] mem [0:31];
    reg [13:0] hdr;
    reg [15:0] sh;
    reg [6:0]  cnt;
    reg [3:0]  rel;
    reg        mdc_q;
    reg        oe_q;
    integer    k;
    wire       hit = hdr[9:5] == 5'd1; // only phy address 1 answers
    // known register pattern so reads can be predicted
    initial begin
        for (k = 0; k < 32; k = k + 1)
            mem[k] = 16'ha5c3 ^ k[15:0];
        cnt = 7'd64;
        rel = 4'd0;
        mdc_q = 1'b0;
        oe_q = 1'b1;
        phy_o = 1'b0;
        phy_oe = 1'b0;
    end
    // mdc rise seen one mclk late, so sampled data is settled, never racing the block
    always @(posedge mclk) begin
        mdc_q <= mdc;
        oe_q <= mdio_oe_n;
        if (oe_q && !mdio_oe_n)
            cnt <= 7'd0;
        else if (mdc && !mdc_q && cnt < 7'd64) begin
            cnt <= cnt + 7'd1;
            if (cnt >= 7'd32 && cnt < 7'd46)
                hdr <= {hdr[12:0], mdio_out};
            if (cnt == 7'd46 && hit && hdr[11:10] == 2'b10) begin
                phy_oe <= 1'b1;
                phy_o <= 1'b0;
            end
            if (cnt == 7'd47)
                {phy_o, sh} <= {mem[hdr[4:0]], 1'b0};
            if (cnt > 7'd47 && cnt < 7'd63)
                {phy_o, sh} <= {sh, mdio_out};
            if (cnt == 7'd63 && hit && hdr[11:10] == 2'b01)
                mem[hdr[4:0]] <= {sh[14:0], mdio_out};
            if (cnt == 7'd63)
                rel <= 4'd6;
        end
        // last bit held past its sampling edge, then line left to the pull-up
        if (rel != 4'd0)
            rel <= rel - 4'd1;
        if (rel == 4'd1)
            phy_oe <= 1'b0;
    end
endmodule

//--- test/mahr_regs_asserts.sv
`timescale 1ns/1ps
module mahr_regs_asserts #(
    parameter HALF_CYC = 25
) (
    input wire        mclk,          // clock
    input wire        rstn,          // reset
    input wire [3:0]  reg_addr,      // index
    input wire [31:0] reg_wdata,     // wdata
    input wire        reg_wr,        // write
    input wire        ee_valid,      // ee strobe
    input wire [2:0]  ee_index,      // ee byte no
    input wire [7:0]  ee_byte,       // ee byte
    input wire        ee_done,       // ee end
    input wire        ee_programmed, // ee present
    input wire        rx_byte_vld,   // da strobe
    input wire        rx_da_start,   // da first
    input wire        mc_check,      // verdict valid
    input wire        mc_accept,     // verdict
    input wire [47:0] station_addr,  // address
    input wire        init_done,     // loaded
    input wire        mdc,           // mgmt clock
    input wire        mdio_out,      // mgmt data
    input wire        mdio_oe_n      // mgmt enable
);
    reg [2:0] nbyte_ff;
    reg       pass_ff;
    reg [7:0] hcnt_ff;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // shadows rebuilt from the ports, since the checker cannot see inside
    always @(posedge mclk) begin
        if (!rstn) begin
            nbyte_ff <= 3'd0;
            pass_ff <= 1'b0;
            hcnt_ff <= 8'd0;
        end else begin
            if (rx_byte_vld)
                nbyte_ff <= rx_da_start ? 3'd1 : nbyte_ff + 3'd1;
            if (reg_wr && reg_addr == 4'h9)
                pass_ff <= reg_wdata[0];
            hcnt_ff <= mdc ? hcnt_ff + 8'd1 : 8'd0;
        end
    end
    a_verdict_time: assert property (rx_byte_vld && !rx_da_start && nbyte_ff == 3'd5
        |=> mc_check) else $error("no verdict after sixth byte");
    a_pass_all: assert property (mc_check && pass_ff |-> mc_accept)
        else $error("pass-all did not accept");
    a_host_low: assert property (init_done && reg_wr && reg_addr == 4'h3 |-> ##2
        station_addr[31:0] == $past(reg_wdata, 2)) else $error("host address write lost");
    a_ee_lane: assert property (ee_valid && ee_programmed && !init_done |-> ##2
        8'(station_addr >> {$past(ee_index, 2) - 3'd1, 3'b000}) == $past(ee_byte, 2))
        else $error("eeprom byte in wrong lane");
    a_ee_unprog: assert property (ee_valid && !ee_programmed |-> ##2
        station_addr == $past(station_addr, 2)) else $error("unprogrammed byte taken");
    a_init_set: assert property (ee_done |-> ##[1:3] init_done)
        else $error("init not flagged after load");
    a_mdc_high: assert property ($fell(mdc) |-> hcnt_ff == HALF_CYC)
        else $error("mdc high phase wrong length");
    a_preamble: assert property ($fell(mdio_oe_n) |-> mdio_out [*8])
        else $error("frame does not open with ones");
endmodule
bind mahr_regs mahr_regs_asserts #(.HALF_CYC(HALF_CYC)) u_mahr_regs_asserts (.mclk, .rstn,
    .reg_addr, .reg_wdata, .reg_wr, .ee_valid, .ee_index, .ee_byte, .ee_done, .ee_programmed,
    .rx_byte_vld, .rx_da_start, .mc_check, .mc_accept, .station_addr, .init_done, .mdc,
    .mdio_out, .mdio_oe_n);

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    reg         mclk, rstn, reg_wr, reg_rd, ee_valid, ee_done, ee_programmed;
    reg         rx_byte_vld, rx_da_start;
    reg  [3:0]  reg_addr;
    reg  [31:0] reg_wdata, q;
    reg  [2:0]  ee_index;
    reg  [7:0]  ee_byte, rx_byte;
    wire [31:0] reg_rdata;
    wire [47:0] station_addr;
    wire        mc_check, mc_accept, init_done, mdc, mdio_out, mdio_oe_n, phy_o, phy_oe;
    wire        mdio_pin = !mdio_oe_n ? mdio_out : (phy_oe ? phy_o : 1'b1); // pull-up
    integer     err_total, cmp_count, i;
    // shortened mdc keeps each frame near 512 cycles
    mahr_regs #(.HALF_CYC(4)) u_mahr_regs (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .ee_valid, .ee_index, .ee_byte, .ee_done, .ee_programmed,
        .rx_byte_vld, .rx_byte, .rx_da_start, .mc_check, .mc_accept, .station_addr,
        .init_done, .mdio_pin, .mdc, .mdio_out, .mdio_oe_n);
    mahr_phy_model u_mahr_phy_model (.mclk, .mdc, .mdio_out, .mdio_oe_n, .phy_o, .phy_oe);
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task chk(input [47:0] got, input [47:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge mclk);
            reg_wr <= 1'b0;
        end
    endtask
    // read data is only valid in the cycle after the strobe
    task rd(input [3:0] a);
        begin
            @(posedge mclk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge mclk);
            reg_rd <= 1'b0;
            #1 q = reg_rdata;
        end
    endtask
    task rchk(input [3:0] a, input [31:0] e);
        begin
            rd(a);
            chk(q, e);
        end
    endtask
    task ee(input [2:0] k, input [7:0] v);
        begin
            @(posedge mclk);
            ee_valid <= 1'b1;
            ee_index <= k;
            ee_byte <= v;
            @(posedge mclk);
            ee_valid <= 1'b0;
        end
    endtask
    // destination bytes go out from bits 7:0 upward; verdict lands one cycle after the last
    task da(input [47:0] a, input e);
        begin
            for (i = 0; i < 6; i = i + 1) begin
                @(posedge mclk);
                rx_byte_vld <= 1'b1;
                rx_da_start <= (i == 0);
                rx_byte <= a[8*i +: 8];
            end
            @(posedge mclk);
            rx_byte_vld <= 1'b0;
            #1 chk(mc_check, 1'b1);
            chk(mc_accept, e);
        end
    endtask
    // reference hash: msb-shifted crc, bits taken lsb first, top six bits
    function [5:0] hidx(input [47:0] a);
        reg [31:0] c;
        integer n;
        begin
            c = 32'hffff_ffff;
            for (n = 0; n < 48; n = n + 1)
                c = {c[30:0], 1'b0} ^ ((c[31] ^ a[n]) ? 32'h04c1_1db7 : 32'h0000_0000);
            hidx = c[31:26];
        end
    endfunction
    task poll;
        integer n;
        begin
            n = 0;
            q = 32'h0000_0001;
            while (q[0] !== 1'b0 && n < 600) begin
                rd(4'h6);
                n = n + 1;
            end
            chk(q[0], 1'b0);
        end
    endtask
    task t_reset;
        begin
            rchk(4'h3, 32'h0fff_ffff);
            rchk(4'h4, 32'h0000_0000);
            rchk(4'h5, 32'h0000_0000);
            rchk(4'h6, 32'h0000_0000);
            rchk(4'h7, 32'h0000_0000);
            rchk(4'h2, 32'h0000_ffff);
            rchk(4'hf, 32'h0000_0000);
            chk(station_addr, 48'hffff_0fff_ffff);
            $display("t_reset done");
        end
    endtask
    task t_addr;
        begin
            ee(3'd1, 8'h55);
            wr(4'h3, 32'h1111_2222);
            rchk(4'h3, 32'h0fff_ffff);
            @(posedge mclk);
            ee_programmed <= 1'b1;
            for (i = 1; i < 7; i = i + 1)
                ee(i[2:0], 8'h22 * i[7:0] - 8'h10);
            @(posedge mclk);
            ee_done <= 1'b1;
            @(posedge mclk);
            ee_done <= 1'b0;
            @(posedge mclk);
            #1 chk(init_done, 1'b1);
            rchk(4'h3, 32'h7856_3412);
            rchk(4'h2, 32'h0000_bc9a);
            chk(station_addr, 48'hbc9a_7856_3412);
            wr(4'h3, 32'hcafe_0001);
            rchk(4'h3, 32'hcafe_0001);
            wr(4'h2, 32'h0000_beef);
            rchk(4'h2, 32'h0000_beef);
            $display("t_addr done");
        end
    endtask
    task t_hash;
        reg [47:0] a0, a1, t;
        reg [5:0]  h;
        begin
            for (i = 0; i < 65536; i = i + 1) begin
                t = {i[15:0], 32'h3322_1101};
                h = hidx(t);
                if (h == 6'd0)
                    a0 = t;
                if (h == 6'd63)
                    a1 = t;
            end
            wr(4'h5, 32'h0000_0001);
            da(a0, 1'b1);
            da(a1, 1'b0);
            rchk(4'ha, 32'h0000_00bf);
            wr(4'h5, 32'h0000_0000);
            wr(4'h4, 32'h8000_0000);
            da(a1, 1'b1);
            da(a0, 1'b0);
            wr(4'h9, 32'h0000_0001);
            rchk(4'h9, 32'h0000_0001);
            da(a0, 1'b1);
            wr(4'h9, 32'h0000_0000);
            rchk(4'h4, 32'h8000_0000);
            $display("t_hash done");
        end
    endtask
    task t_phy;
        begin
            wr(4'h7, 32'h0000_5a3c);
            wr(4'h6, 32'h0000_0943);
            rd(4'h6);
            chk(q[0], 1'b1);
            wr(4'h7, 32'h0000_ffff);
            poll;
            chk(q, 32'h0000_0942);
            rchk(4'h7, 32'h0000_5a3c);
            chk(u_mahr_phy_model.mem[5], 16'h5a3c);
            wr(4'h6, 32'h0000_0a41);
            poll;
            chk(q, 32'h0000_0a40);
            rchk(4'h7, 32'h0000_a5ca);
            $display("t_phy done");
        end
    endtask
    task test_done;
        begin
            $display("cmp_count=%0d err_total=%0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // main sequence; reset held for 20 cycles
    initial begin
        err_total = 0;
        cmp_count = 0;
        {rstn, reg_wr, reg_rd, ee_valid, ee_done, ee_programmed} = 6'd0;
        {rx_byte_vld, rx_da_start, reg_addr, reg_wdata} = 38'd0;
        {ee_index, ee_byte, rx_byte} = 19'd0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        t_reset;
        t_addr;
        t_hash;
        t_phy;
        test_done;
    end
    // watchdog well beyond the roughly 1200 cycles the tests need
    initial begin
        #400000;
        err_total = err_total + 1;
        test_done;
    end
endmodule
